// File: mdio_pkg.sv
/*
 * Shared constants and types for the MDIO management block: region
 * decode, register offsets, control field layout, frame timing.
 * Assumes a 32-bit APB master running on pclk.
 */
package mdio_pkg;
	// ----------------------------------------------------------------
	// Address regions
	// ----------------------------------------------------------------
	localparam logic [31:0] MAC_BASE = 32'h0000_0400;
	localparam logic [31:0] MAC_LAST = 32'h0000_04FC;
	localparam logic [31:0] MDIO_BASE = 32'h0000_0500;
	localparam logic [31:0] MDIO_LAST = 32'h0000_05FC;
	localparam logic [31:0] INTC_BASE = 32'h0000_0600;
	localparam logic [31:0] INTC_LAST = 32'h0000_06FC;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [31:0] RCV_CFG_ADDR = 32'h0000_0404;
	localparam logic [31:0] XMT_CFG_ADDR = 32'h0000_0408;
	localparam logic [31:0] MGMT_CFG_ADDR = 32'h0000_0500;
	localparam logic [31:0] MGMT_CTRL_ADDR = 32'h0000_0504;
	localparam logic [31:0] MGMT_WDATA_ADDR = 32'h0000_0508;
	localparam logic [31:0] MGMT_RDATA_ADDR = 32'h0000_050C;
	localparam logic [31:0] IRQ_STAT_ADDR = 32'h0000_0600;
	localparam logic [31:0] IRQ_ENA_ADDR = 32'h0000_0608;
	localparam logic [31:0] IRQ_CLR_ADDR = 32'h0000_060C;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CFG_DIV_LSB = 0;
	localparam int CFG_ENA_BIT = 6;
	localparam int CFG_SOFT_RST_BIT = 31;
	localparam int CTRL_READY_BIT = 7;
	localparam int CTRL_START_BIT = 11;
	localparam int CTRL_OP_LSB = 14;
	localparam int CTRL_REG_LSB = 16;
	localparam int CTRL_PHY_LSB = 24;
	localparam int RDATA_READY_BIT = 16;
	localparam logic [5:0] DIV_RESET = 6'h00;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] START_CODE = 2'h1;
	localparam logic [1:0] TA_WRITE = 2'h2;
	// ----------------------------------------------------------------
	// Frame timing: 32 preamble + 32 frame bits
	// ----------------------------------------------------------------
	localparam logic [6:0] FRAME_BITS = 7'h40;
	localparam logic [6:0] READ_RELEASE_BIT = 7'h2E;
	localparam logic [6:0] DATA_FIRST_BIT = 7'h30;
	localparam logic [31:0] PREAMBLE = 32'hFFFF_FFFF;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;

	typedef struct packed {
		logic [1:0] op;
		logic [4:0] phy;
		logic [4:0] reg_ad;
		logic [15:0] data;
	} mdio_cmd_t;

	typedef struct packed {
		logic mdc;
		logic mdio_o;
		logic mdio_t;
	} mdio_pins_t;
endpackage

// File: mdio_shifter.sv
/*
 * MDIO frame engine: divides pclk into mdc and shifts one clause-22
 * frame out, releasing the line for read turnaround and data.
 * Assumes start is a one-cycle pulse taken only while idle.
 */
`timescale 1ns/100ps
module mdio_shifter
	import mdio_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [5:0] divisor,
	input wire logic start,
	input wire mdio_cmd_t cmd,
	input wire logic mdio_i,
	output mdio_pins_t pins,
	output logic busy,
	output logic done,
	output logic [15:0] rdata
);
	typedef enum logic [1:0] {
		S_IDLE = 2'b01,
		S_SHIFT = 2'b10
	} sh_state_t;

	sh_state_t state_r, state_nxt;
	logic [5:0] div_cnt_r, div_cnt_nxt;
	logic [6:0] bit_r, bit_nxt;
	logic [63:0] sreg_r, sreg_nxt;
	logic [15:0] rd_r, rd_nxt;
	mdio_pins_t pins_r, pins_nxt;
	logic done_r, done_nxt;
	// Frame kind is held here, so a control write during the frame cannot change it
	logic read_r, read_nxt;

	always_comb begin
		state_nxt = state_r;
		div_cnt_nxt = div_cnt_r;
		bit_nxt = bit_r;
		sreg_nxt = sreg_r;
		rd_nxt = rd_r;
		pins_nxt = pins_r;
		done_nxt = 1'b0;
		read_nxt = read_r;
		case (state_r)
			S_IDLE: begin
				pins_nxt.mdc = 1'b0;
				pins_nxt.mdio_t = 1'b1;
				if (start) begin
					sreg_nxt = {PREAMBLE, START_CODE, cmd.op, cmd.phy, cmd.reg_ad,
						TA_WRITE, cmd.data};
					bit_nxt = '0;
					read_nxt = (cmd.op == OP_READ);
					div_cnt_nxt = divisor;
					state_nxt = S_SHIFT;
					pins_nxt.mdio_o = 1'b1;
					pins_nxt.mdio_t = 1'b0;
				end
			end
			S_SHIFT: begin
				if (div_cnt_r != '0) begin
					div_cnt_nxt = div_cnt_r - 6'h01;
				end else begin
					div_cnt_nxt = divisor;
					pins_nxt.mdc = ~pins_r.mdc;
					// change data after falling edge, sample at rising
					if (pins_r.mdc) begin
						bit_nxt = bit_r + 7'h01;
						sreg_nxt = {sreg_r[62:0], 1'b0};
						if (bit_r + 7'h01 == FRAME_BITS) begin
							state_nxt = S_IDLE;
							pins_nxt.mdio_t = 1'b1;
							done_nxt = 1'b1;
						end else begin
							pins_nxt.mdio_o = sreg_r[62];
							pins_nxt.mdio_t = read_r &&
								(bit_r + 7'h01 >= READ_RELEASE_BIT);
						end
					end else if (read_r && (bit_r >= DATA_FIRST_BIT)) begin
						rd_nxt = {rd_r[14:0], mdio_i};
					end
				end
			end
			default: begin
				state_nxt = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= S_IDLE;
			div_cnt_r <= '0;
			bit_r <= '0;
			sreg_r <= '0;
			rd_r <= '0;
			pins_r <= '{mdc: 1'b0, mdio_o: 1'b1, mdio_t: 1'b1};
			done_r <= 1'b0;
			read_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			div_cnt_r <= div_cnt_nxt;
			bit_r <= bit_nxt;
			sreg_r <= sreg_nxt;
			rd_r <= rd_nxt;
			pins_r <= pins_nxt;
			done_r <= done_nxt;
			read_r <= read_nxt;
		end
	end

	assign pins = pins_r;
	assign busy = (state_r != S_IDLE);
	assign done = done_r;
	assign rdata = rd_r;
endmodule

// File: mdio_mgmt.sv
/*
 * Management port: APB slave with region decode, MAC configuration
 * staging, MDIO control/status and completion interrupt.
 * Assumes a single pclk domain and an external three-state buffer
 * joining mdio_i, mdio_o and mdio_t.
 */
`timescale 1ns/100ps
// What this block does
// - Answer illegal or unmapped bus accesses with an error response.
// - Decode MAC config, MDIO and interrupt regions; others reserved.
// - Accept RX/TX configuration writes anytime; apply only between frames.
// - Soft reset bits take effect immediately.
// - mdc is pclk divided by twice (divisor plus one).
// - Divisor resets to zero; zero divisor blocks MDIO enable.
// - This block starts every MDIO transfer; addressed PHY responds.
// - Frame bits shift on the data line synchronous to mdc.
// - Write frame uses opcode 01 and carries sixteen data bits.
// - Read frame uses opcode 10; PHY data is captured.
// - Start clears ready; ready stays low until frame ends.
// - After a read, captured value appears in read-data register.
// - Ready flag visible in control and read-data registers.
// - Interrupt raised when a pending MDIO transfer completes.
module mdio_mgmt
	import mdio_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_in_frame,
	input wire logic tx_in_frame,
	output logic [31:0] rx_config,
	output logic [31:0] tx_config,
	output logic soft_reset,
	input wire logic mdio_i,
	output logic mdc,
	output logic mdio_o,
	output logic mdio_t,
	output logic irq
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic [31:0] rx_stage_r, rx_stage_nxt;
	logic [31:0] tx_stage_r, tx_stage_nxt;
	logic [31:0] rx_cfg_r, rx_cfg_nxt;
	logic [31:0] tx_cfg_r, tx_cfg_nxt;
	logic soft_rst_r, soft_rst_nxt;
	logic [5:0] div_r, div_nxt;
	logic ena_r, ena_nxt;
	mdio_cmd_t cmd_r, cmd_nxt;
	logic [15:0] wdata_r, wdata_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic ready_r, ready_nxt;
	logic start_r, start_nxt;
	logic pend_r, pend_nxt;
	logic ist_r, ist_nxt;
	logic ien_r, ien_nxt;
	logic irq_r, irq_nxt;

	mdio_pins_t pins;
	logic eng_busy;
	logic eng_done;
	logic [15:0] eng_rdata;

	function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
		input logic [31:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		merge = r;
	endfunction

	// ----------------------------------------------------------------
	// Bus and register logic
	// ----------------------------------------------------------------
	logic access;
	logic known;
	logic [31:0] rd_word;
	logic [31:0] wv;

	always_comb begin
		access = psel && penable && !pready_r;
		prdata_nxt = prdata_r;
		pready_nxt = access;
		pslverr_nxt = 1'b0;
		rx_stage_nxt = rx_stage_r;
		tx_stage_nxt = tx_stage_r;
		rx_cfg_nxt = rx_cfg_r;
		tx_cfg_nxt = tx_cfg_r;
		soft_rst_nxt = soft_rst_r;
		div_nxt = div_r;
		ena_nxt = ena_r;
		cmd_nxt = cmd_r;
		wdata_nxt = wdata_r;
		rdata_nxt = rdata_r;
		ready_nxt = ready_r;
		start_nxt = 1'b0;
		pend_nxt = pend_r;
		ist_nxt = ist_r;
		ien_nxt = ien_r;
		known = 1'b1;
		rd_word = ZERO32;
		wv = ZERO32;

		if (!rx_in_frame) begin
			rx_cfg_nxt = rx_stage_r;
		end
		if (!tx_in_frame) begin
			tx_cfg_nxt = tx_stage_r;
		end

		case (paddr)
			RCV_CFG_ADDR: rd_word = rx_stage_r;
			XMT_CFG_ADDR: rd_word = tx_stage_r;
			MGMT_CFG_ADDR: begin
				rd_word[CFG_DIV_LSB +: 6] = div_r;
				rd_word[CFG_ENA_BIT] = ena_r;
				rd_word[CFG_SOFT_RST_BIT] = soft_rst_r;
			end
			MGMT_CTRL_ADDR: begin
				rd_word[CTRL_OP_LSB +: 2] = cmd_r.op;
				rd_word[CTRL_REG_LSB +: 5] = cmd_r.reg_ad;
				rd_word[CTRL_PHY_LSB +: 5] = cmd_r.phy;
				rd_word[CTRL_READY_BIT] = ready_r;
			end
			MGMT_WDATA_ADDR: rd_word[15:0] = wdata_r;
			MGMT_RDATA_ADDR: begin
				rd_word[15:0] = rdata_r;
				rd_word[RDATA_READY_BIT] = ready_r;
			end
			IRQ_STAT_ADDR: rd_word[0] = ist_r;
			IRQ_ENA_ADDR: rd_word[0] = ien_r;
			IRQ_CLR_ADDR: rd_word = ZERO32;
			default: known = 1'b0;
		endcase

		if (!(in_range(paddr, MAC_BASE, MAC_LAST) || in_range(paddr, MDIO_BASE, MDIO_LAST)
			|| in_range(paddr, INTC_BASE, INTC_LAST))) begin
			known = 1'b0;
		end

		if (access) begin
			if (!known || (pwrite && (paddr == MGMT_RDATA_ADDR))) begin
				pslverr_nxt = 1'b1;
			end else if (!pwrite) begin
				prdata_nxt = rd_word;
			end else begin
				case (paddr)
					RCV_CFG_ADDR: rx_stage_nxt = merge(rx_stage_r, pwdata, pstrb);
					XMT_CFG_ADDR: tx_stage_nxt = merge(tx_stage_r, pwdata, pstrb);
					MGMT_CFG_ADDR: begin
						wv = merge({soft_rst_r, 24'h00_0000, ena_r, div_r}, pwdata, pstrb);
						div_nxt = wv[CFG_DIV_LSB +: 6];
						soft_rst_nxt = wv[CFG_SOFT_RST_BIT];
						ena_nxt = wv[CFG_ENA_BIT] && (wv[CFG_DIV_LSB +: 6] != DIV_RESET);
					end
					MGMT_CTRL_ADDR: begin
						wv = merge(ZERO32, pwdata, pstrb);
						cmd_nxt.op = wv[CTRL_OP_LSB +: 2];
						cmd_nxt.reg_ad = wv[CTRL_REG_LSB +: 5];
						cmd_nxt.phy = wv[CTRL_PHY_LSB +: 5];
						cmd_nxt.data = wdata_r;
						if (wv[CTRL_START_BIT] && ready_r && !eng_busy && ena_r &&
							(wv[CTRL_OP_LSB +: 2] == OP_WRITE ||
							wv[CTRL_OP_LSB +: 2] == OP_READ)) begin
							start_nxt = 1'b1;
							ready_nxt = 1'b0;
							pend_nxt = 1'b1;
						end
					end
					MGMT_WDATA_ADDR: begin
						wv = merge({16'h0000, wdata_r}, pwdata, pstrb);
						wdata_nxt = wv[15:0];
					end
					IRQ_ENA_ADDR: ien_nxt = pwdata[0];
					IRQ_CLR_ADDR: begin
						if (pwdata[0]) begin
							ist_nxt = 1'b0;
						end
					end
					default: pslverr_nxt = 1'b1;
				endcase
			end
		end

		if (eng_done) begin
			// capture read result; a write frame leaves the last read word
			rdata_nxt = eng_rdata;
			ready_nxt = 1'b1;
			pend_nxt = 1'b0;
			if (pend_r) begin
				ist_nxt = 1'b1;
			end
		end
		irq_nxt = ist_nxt && ien_nxt;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= ZERO32;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			rx_stage_r <= ZERO32;
			tx_stage_r <= ZERO32;
			rx_cfg_r <= ZERO32;
			tx_cfg_r <= ZERO32;
			soft_rst_r <= 1'b0;
			div_r <= DIV_RESET;
			ena_r <= 1'b0;
			cmd_r <= '0;
			wdata_r <= 16'h0000;
			rdata_r <= 16'h0000;
			ready_r <= 1'b1;
			start_r <= 1'b0;
			pend_r <= 1'b0;
			ist_r <= 1'b0;
			ien_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			rx_stage_r <= rx_stage_nxt;
			tx_stage_r <= tx_stage_nxt;
			rx_cfg_r <= rx_cfg_nxt;
			tx_cfg_r <= tx_cfg_nxt;
			soft_rst_r <= soft_rst_nxt;
			div_r <= div_nxt;
			ena_r <= ena_nxt;
			cmd_r <= cmd_nxt;
			wdata_r <= wdata_nxt;
			rdata_r <= rdata_nxt;
			ready_r <= ready_nxt;
			start_r <= start_nxt;
			pend_r <= pend_nxt;
			ist_r <= ist_nxt;
			ien_r <= ien_nxt;
			irq_r <= irq_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Frame engine
	// ----------------------------------------------------------------
	// write frame; read release inside engine
	mdio_shifter u_shift (
		.pclk(pclk),
		.presetn(presetn),
		.divisor(div_r),
		.start(start_r),
		.cmd(cmd_r),
		.mdio_i(mdio_i),
		.pins(pins),
		.busy(eng_busy),
		.done(eng_done),
		.rdata(eng_rdata)
	);

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign rx_config = rx_cfg_r;
	assign tx_config = tx_cfg_r;
	assign soft_reset = soft_rst_r;
	assign mdc = pins.mdc;
	assign mdio_o = pins.mdio_o;
	assign mdio_t = pins.mdio_t;
	assign irq = irq_r;
endmodule

// File: mdio_mgmt_chk.sv
/* Checker on mdio_mgmt ports: bus answers, mdc timing, frame layout.
   Assumes one pclk domain and writes that take effect at pready. */
`timescale 1ns/100ps
module mdio_mgmt_chk
	import mdio_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic mdc,
	input wire logic mdio_o,
	input wire logic mdio_t
);
	// ------
	// Tracking
	// ------
	// Bit index wraps every 64 rises, so a frame of the wrong length skews all later checks
	logic [5:0] div_r, div_nxt, bit_r, bit_nxt;
	logic [6:0] hi_r, hi_nxt;
	logic [1:0] op_r, op_nxt;
	logic mdc_r, wr_done;
	assign wr_done = psel && penable && pready && pwrite;
	always_comb begin
		div_nxt = div_r;
		op_nxt = op_r;
		if (wr_done && paddr == MGMT_CFG_ADDR && pstrb[0]) begin
			div_nxt = pwdata[5:0];
		end
		if (wr_done && paddr == MGMT_CTRL_ADDR && pwdata[CTRL_START_BIT]) begin
			op_nxt = pwdata[15:14];
		end
		hi_nxt = mdc ? hi_r + 7'h01 : 7'h00;
		bit_nxt = (mdc && !mdc_r) ? bit_r + 6'h01 : bit_r;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= DIV_RESET;
			op_r <= 2'h0;
			hi_r <= 7'h00;
			bit_r <= 6'h00;
			mdc_r <= 1'b0;
		end else begin
			div_r <= div_nxt;
			op_r <= op_nxt;
			hi_r <= hi_nxt;
			bit_r <= bit_nxt;
			mdc_r <= mdc;
		end
	end
	// ------
	// Properties
	// ------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_take;
		psel && penable && !pready;
	endsequence
	sequence s_rise;
		$rose(mdc);
	endsequence
	chk_answer_next: assert property (s_take |=> pready)
		else $error("bus access not answered");
	chk_err_reserved: assert property (
		s_take ##0 (paddr < MAC_BASE || paddr > INTC_LAST) |=> pslverr)
		else $error("reserved access not refused");
	chk_mdc_half: assert property ($fell(mdc) |-> hi_r == {1'b0, div_r} + 7'h01)
		else $error("mdc high phase wrong");
	chk_div_zero: assert property (div_r == DIV_RESET |-> !mdc && mdio_t)
		else $error("mdio active with zero divisor");
	chk_preamble_ones: assert property (
		s_rise ##0 (bit_r < 6'h20) |-> mdio_o && !mdio_t)
		else $error("preamble bit wrong");
	chk_start_code: assert property (
		s_rise ##0 (bit_r[5:1] == 5'h10) |-> mdio_o == bit_r[0])
		else $error("start bits wrong");
	chk_op_code: assert property (
		s_rise ##0 (bit_r[5:1] == 5'h11) |-> mdio_o == op_r[~bit_r[0]])
		else $error("operation bits wrong");
	chk_read_release: assert property (
		s_rise ##0 (bit_r >= 6'h2E) |-> mdio_t == (op_r == OP_READ))
		else $error("line release wrong");
endmodule
bind mdio_mgmt mdio_mgmt_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pstrb, .pready, .pslverr, .mdc, .mdio_o, .mdio_t);

// File: mdio_phy_model.sv
/* Behavioural PHY on the MDIO line: records each frame, answers reads.
   Assumes the bench resolves the line with a pull-up. */
`timescale 1ns/100ps
module mdio_phy_model
	import mdio_pkg::*;
(
	input wire logic mdc,
	input wire logic mdio,
	input wire logic [15:0] reg_value,
	output logic drive_n,
	output logic drive_bit,
	output mdio_cmd_t seen,
	output int frames
);
	int n;
	initial begin
		drive_n = 1'b1;
		drive_bit = 1'b1;
		seen = '0;
		frames = 0;
		forever begin
			n = 0;
			while (n < 32) begin
				@(posedge mdc);
				n = mdio ? n + 1 : 0;
			end
			do @(posedge mdc); while (mdio);
			@(posedge mdc);
			repeat (12) begin
				@(posedge mdc);
				seen[27:16] = {seen[26:16], mdio};
			end
			if (seen.op == OP_READ) begin
				seen.data = reg_value;
				@(posedge mdc);
				@(negedge mdc);
				drive_n = 1'b0;
				drive_bit = 1'b0;
				for (n = 15; n >= 0; n--) begin
					@(negedge mdc);
					drive_bit = seen.data[n];
				end
				@(negedge mdc);
				drive_n = 1'b1;
			end else begin
				repeat (18) begin
					@(posedge mdc);
					seen.data = {seen.data[14:0], mdio};
				end
			end
			frames = frames + 1;
		end
	end
endmodule

// File: test_mdio_mgmt.sv
/* Bench for mdio_mgmt: APB master noting expectations in a queue, PHY model
   on the resolved MDIO line. Assumes pclk at 10 MHz and the bound checker. */
`timescale 1ns/100ps
module test_mdio_mgmt
	import mdio_pkg::*;
;
	typedef struct packed {
		logic err;
		logic [31:0] mask;
		logic [31:0] exp;
	} note_t;
	note_t notes[$];
	note_t nt;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, seed = 32'h0000_0032;
	logic [3:0] pstrb = 4'h0;
	logic rx_in_frame = 1'b0, tx_in_frame = 1'b0;
	logic [31:0] prdata, rx_config, tx_config, rd, v0, v1;
	logic pready, pslverr, soft_reset, mdc, mdio_o, mdio_t, irq, line, drive_n, drive_bit;
	logic [15:0] phy_value = 16'h0000;
	logic [4:0] pa = 5'h00, ra = 5'h00;
	logic [31:0] bad [4] = '{32'h0000_0000, 32'h0000_0700, 32'h0000_0510, MGMT_RDATA_ADDR};
	mdio_cmd_t seen;
	int frames, failures = 0, check_count = 0, i;
	assign line = !mdio_t ? mdio_o : (!drive_n ? drive_bit : 1'b1);
	mdio_mgmt i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .rx_in_frame, .tx_in_frame, .rx_config, .tx_config,
		.soft_reset, .mdio_i(line), .mdc, .mdio_o, .mdio_t, .irq);
	mdio_phy_model i_phy (.mdc, .mdio(line), .reg_value(phy_value), .drive_n, .drive_bit,
		.seen, .frames);
	initial forever #50 pclk = ~pclk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic give_verdict();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, d, input logic [3:0] s,
		input logic [31:0] e, m, input logic err);
		int k;
		notes.push_back('{err, m, e});
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			failures++;
			give_verdict();
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [31:0] a, d);
		apb(1'b1, a, d, 4'hF, ZERO32, ZERO32, 1'b0);
	endtask
	task automatic rdx(input logic [31:0] a, e, m);
		apb(1'b0, a, ZERO32, 4'hF, e, m, 1'b0);
	endtask
	task automatic go(input logic [1:0] op);
		wr(MGMT_CTRL_ADDR, {3'h0, pa, 3'h0, ra, op, 2'h0, 1'b1, 11'h000});
	endtask
	task automatic wait_ready(input logic [31:0] a, input int b);
		int k;
		k = 0;
		do begin
			rdx(a, ZERO32, ZERO32);
			k++;
		end while (rd[b] !== 1'b1 && k < 200);
		chk("ready", 32'h0000_0001, 32'(rd[b]));
	endtask
	// Answers are compared here, oldest note first
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
			nt = notes.pop_front();
			check_count++;
			if ((prdata & nt.mask) !== (nt.exp & nt.mask) || pslverr !== nt.err) begin
				failures++;
				$display("mismatch reg %h expected %h seen %h", paddr, {nt.err, nt.exp},
					{pslverr, prdata & nt.mask});
			end
		end
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rdx(MGMT_CFG_ADDR, ZERO32, 32'hFFFF_FFFF);
		rdx(MGMT_CTRL_ADDR, 32'h0000_0080, 32'h0000_0080);
		wr(MGMT_CFG_ADDR, 32'h0000_0040);
		rdx(MGMT_CFG_ADDR, ZERO32, 32'h0000_007F);
		go(OP_WRITE);
		rdx(MGMT_CTRL_ADDR, 32'h0000_0080, 32'h0000_0080);
		for (i = 0; i < 4; i++) apb(i == 3, bad[i], ZERO32, 4'hF, ZERO32, ZERO32, 1'b1);
		$display("test reset_and_refusals done");
		apb(1'b1, MGMT_CFG_ADDR, 32'h8000_0041, 4'h1, ZERO32, ZERO32, 1'b0);
		rdx(MGMT_CFG_ADDR, 32'h0000_0041, 32'hFFFF_FFFF);
		rx_in_frame <= 1'b1;
		tx_in_frame <= 1'b1;
		seed = xs(seed);
		v0 = seed;
		seed = xs(seed);
		v1 = seed;
		wr(RCV_CFG_ADDR, v0);
		wr(XMT_CFG_ADDR, v1);
		rdx(RCV_CFG_ADDR, v0, 32'hFFFF_FFFF);
		repeat (3) @(posedge pclk);
		chk("rx_config", ZERO32, rx_config);
		rx_in_frame <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("rx_config", v0, rx_config);
		chk("tx_config", ZERO32, tx_config);
		tx_in_frame <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("tx_config", v1, tx_config);
		$display("test config_staging done");
		wr(IRQ_ENA_ADDR, 32'h0000_0001);
		seed = xs(seed);
		pa = seed[4:0] | 5'h01;
		ra = seed[12:8];
		wr(MGMT_WDATA_ADDR, {16'h0000, seed[31:16]});
		go(OP_WRITE);
		rdx(MGMT_CTRL_ADDR, ZERO32, 32'h0000_0080);
		wait_ready(MGMT_CTRL_ADDR, CTRL_READY_BIT);
		chk("frame", {4'h0, OP_WRITE, pa, ra, seed[31:16]}, {4'h0, seen});
		chk("irq", 32'h0000_0001, 32'(irq));
		rdx(IRQ_STAT_ADDR, 32'h0000_0001, 32'h0000_0001);
		wr(IRQ_CLR_ADDR, 32'h0000_0001);
		chk("irq", ZERO32, 32'(irq));
		$display("test mdio_write done");
		seed = xs(seed);
		phy_value <= seed[15:0];
		go(OP_READ);
		wait_ready(MGMT_RDATA_ADDR, RDATA_READY_BIT);
		rdx(MGMT_RDATA_ADDR, {15'h0000, 1'b1, seed[15:0]}, 32'h0001_FFFF);
		chk("op", 32'(OP_READ), 32'(seen.op));
		i = frames;
		go(2'h0);
		rdx(MGMT_CTRL_ADDR, 32'h0000_0080, 32'h0000_0080);
		repeat (300) @(posedge pclk);
		chk("frames", 32'(i), 32'(frames));
		$display("test mdio_read done");
		rx_in_frame <= 1'b1;
		wr(MGMT_CFG_ADDR, 32'h8000_0041);
		chk("soft_reset", 32'h0000_0001, 32'(soft_reset));
		$display("test soft_reset done");
		give_verdict();
	end
endmodule
